// ===== amp_control_diag_serial_port.sv
`timescale 1ns/1ns
// Operation
// - Fast mute bit shortens mute below 1.5 ms.
// - Open select pin: bus ignored, pin control.
// - Pin mode: pins pick efficiency and gain.
// - Select pin strap fixes slave address.
// - Start and stop framed while clock high.
// - Data changes only while clock low.
// - Eight bits, MSB first, then acknowledge.
// - Receiver pulls data low on acknowledge.
// - Address lowest bit selects write or read.
// - Write takes two control bytes in order.
// - First byte: diagnostics and offset enables.
// - First byte: gains, unmutes, clip threshold.
// - Second byte: threshold, standby, diagnostic mode.
// - Second byte: peak diagnostic, efficiency modes.
// - Read returns four status bytes in order.
// - Status one: thermal warning, cycle done.
// - Status one low bits: channel three faults.
// - Read restarts diagnostics, returns previous results.
// - Other status bytes: channels four, one, two.
module amp_control_diag_serial_port #(
  parameter int FAST_MUTE_CYCLES = amp_serial_pkg::FAST_MUTE_CYCLES,
  parameter int NORMAL_MUTE_CYCLES = amp_serial_pkg::NORMAL_MUTE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [1:0] addressSelectStrap,
  input wire logic standbyMutePin,
  input wire logic efficiencySelectPin,
  input wire amp_serial_pkg::diagStatus_type diagStatus,
  output amp_serial_pkg::ampControl_type ampControl,
  output logic frontUnmuted,
  output logic rearUnmuted,
  output logic diagRestart
);

  // Synchronised pins: strap (2), standby-mute, efficiency, data, clock.
  logic [5:0] pinsSync;
  logic sclS;
  logic sdaS;
  logic effS;
  logic stbyS;
  logic [1:0] strapS;

  pin_sync #(
    .W(6)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .din({addressSelectStrap, standbyMutePin, efficiencySelectPin, sdaIn, sclPin}),
    .dout(pinsSync)
  );

  assign sclS = pinsSync[0];
  assign sdaS = pinsSync[1];
  assign effS = pinsSync[2];
  assign stbyS = pinsSync[3];
  assign strapS = pinsSync[5:4];

  // All block state in one record.
  typedef struct packed {
    amp_serial_pkg::busState_type state;
    logic sclPrev;
    logic sdaPrev;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic [1:0] byteIdx;
    logic rw;
    logic hostAck;
    logic sdaOe;
    logic diagRestart;
    logic [7:0] ctlFirst;
    logic [7:0] ctlSecond;
    logic [3:0][7:0] snap;
    amp_serial_pkg::ampControl_type ctl;
  } portState_type;

  portState_type q;
  portState_type next_q;

  // Bus condition decode from the synchronised lines.
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic busOff;
  logic [6:0] myAddr;
  amp_serial_pkg::ampControl_type regCtl;
  amp_serial_pkg::ampControl_type pinCtl;

  // Both lines are compared with their value one cycle back, so a data edge
  // while the clock is high marks a frame boundary.
  always_comb begin
    sclRise = sclS & ~q.sclPrev;
    sclFall = ~sclS & q.sclPrev;
    startCond = sclS & q.sclPrev & q.sdaPrev & ~sdaS;
    stopCond = sclS & q.sclPrev & ~q.sdaPrev & sdaS;
    busOff = strapS[1];
    myAddr = amp_serial_pkg::ADDR_BASE | {6'h00, strapS[0]};
  end

  // Decode of the two control bytes into settings.
  always_comb begin
    regCtl.diagEnable = q.ctlFirst[amp_serial_pkg::CB1_DIAG_EN];
    regCtl.offsetEnable = q.ctlFirst[amp_serial_pkg::CB1_OFFSET_EN];
    regCtl.gainFront16 = q.ctlFirst[amp_serial_pkg::CB1_GAIN_FRONT];
    regCtl.gainRear16 = q.ctlFirst[amp_serial_pkg::CB1_GAIN_REAR];
    regCtl.unmuteFront = q.ctlFirst[amp_serial_pkg::CB1_UNMUTE_FRONT];
    regCtl.unmuteRear = q.ctlFirst[amp_serial_pkg::CB1_UNMUTE_REAR];
    regCtl.clipTen = q.ctlFirst[amp_serial_pkg::CB1_CLIP];
    regCtl.lowCurrentThreshold = q.ctlSecond[amp_serial_pkg::CB2_LOW_TH];
    regCtl.fastMute = q.ctlSecond[amp_serial_pkg::CB2_FAST_MUTE];
    regCtl.standbyOff = q.ctlSecond[amp_serial_pkg::CB2_STANDBY_OFF];
    regCtl.lineDriverDiag = q.ctlSecond[amp_serial_pkg::CB2_LINE_DIAG];
    regCtl.peakCurrentDiag = q.ctlSecond[amp_serial_pkg::CB2_PEAK_DIAG];
    regCtl.highEffRight = q.ctlSecond[amp_serial_pkg::CB2_HE_RIGHT];
    regCtl.highEffLeft = q.ctlSecond[amp_serial_pkg::CB2_HE_LEFT];
  end

  // Pin-controlled settings; the data line doubles as the gain select.
  always_comb begin
    pinCtl = '0;
    pinCtl.standbyOff = stbyS;
    pinCtl.unmuteFront = stbyS;
    pinCtl.unmuteRear = stbyS;
    pinCtl.gainFront16 = sdaS;
    pinCtl.gainRear16 = sdaS;
    pinCtl.highEffRight = effS;
    pinCtl.highEffLeft = effS;
  end

  // Slave sequencer. Bits are taken on clock rise and the data driver only
  // moves on clock fall, so the line is steady while the clock is high.
  always_comb begin
    next_q = q;
    next_q.sclPrev = sclS;
    next_q.sdaPrev = sdaS;
    next_q.diagRestart = 1'b0;
    if (busOff) begin
      // Bus ignored; the driver stays released.
      next_q.state = amp_serial_pkg::IDLE;
      next_q.sdaOe = 1'b0;
    end else if (startCond) begin
      // A start, repeated or not, always opens a new address byte.
      next_q.state = amp_serial_pkg::ADDR;
      next_q.bitCnt = 4'h0;
      next_q.sdaOe = 1'b0;
    end else if (stopCond) begin
      next_q.state = amp_serial_pkg::IDLE;
      next_q.sdaOe = 1'b0;
    end else begin
      case (q.state)
        amp_serial_pkg::ADDR, amp_serial_pkg::WRITE: begin
          if (sclRise && (q.bitCnt < amp_serial_pkg::BITS_PER_BYTE)) begin
            // Most significant bit arrives first.
            next_q.shift = {q.shift[6:0], sdaS};
            next_q.bitCnt = q.bitCnt + 4'h1;
          end else if (sclFall && (q.bitCnt == amp_serial_pkg::BITS_PER_BYTE)) begin
            if (q.state == amp_serial_pkg::ADDR) begin
              if (q.shift[7:1] == myAddr) begin
                next_q.sdaOe = 1'b1;
                next_q.rw = q.shift[0];
                next_q.state = amp_serial_pkg::ADDR_ACK;
                next_q.byteIdx = 2'h0;
                if (q.shift[0]) begin
                  // Results of the finished cycle are frozen, then a new cycle starts.
                  next_q.snap[0] = {diagStatus.thermalWarning1, diagStatus.diagDone,
                                    diagStatus.fault[2]};
                  next_q.snap[1] = {q.ctl.offsetEnable, 1'b0, diagStatus.fault[3]};
                  next_q.snap[2] = {q.ctl.standbyOff, q.ctl.diagEnable,
                                    diagStatus.fault[0]};
                  next_q.snap[3] = {diagStatus.thermalWarning2, diagStatus.thermalWarning3,
                                    diagStatus.fault[1]};
                  next_q.diagRestart = 1'b1;
                end
              end else begin
                // Another slave is addressed; wait for the next start.
                next_q.state = amp_serial_pkg::IDLE;
              end
            end else if (q.byteIdx <= amp_serial_pkg::LAST_CONTROL_INDEX) begin
              if (q.byteIdx == 2'h0) begin
                next_q.ctlFirst = q.shift;
              end else begin
                next_q.ctlSecond = q.shift;
              end
              next_q.sdaOe = 1'b1;
              next_q.state = amp_serial_pkg::WRITE_ACK;
            end else begin
              // Bytes past the second are refused with a released line.
              next_q.state = amp_serial_pkg::IDLE;
            end
          end
        end
        amp_serial_pkg::ADDR_ACK: begin
          if (sclFall) begin
            next_q.bitCnt = 4'h0;
            if (q.rw) begin
              next_q.state = amp_serial_pkg::READ;
              next_q.sdaOe = ~q.snap[0][7];
            end else begin
              next_q.state = amp_serial_pkg::WRITE;
              next_q.sdaOe = 1'b0;
            end
          end
        end
        amp_serial_pkg::WRITE_ACK: begin
          if (sclFall) begin
            next_q.sdaOe = 1'b0;
            next_q.state = amp_serial_pkg::WRITE;
            next_q.bitCnt = 4'h0;
            next_q.byteIdx = q.byteIdx + 2'h1;
          end
        end
        amp_serial_pkg::READ: begin
          if (sclFall) begin
            next_q.bitCnt = q.bitCnt + 4'h1;
            if (q.bitCnt == 4'h7) begin
              // Release for the host's acknowledge.
              next_q.sdaOe = 1'b0;
              next_q.state = amp_serial_pkg::READ_ACK;
            end else begin
              next_q.sdaOe = ~q.snap[q.byteIdx][3'h6 - q.bitCnt[2:0]];
            end
          end
        end
        amp_serial_pkg::READ_ACK: begin
          if (sclRise) begin
            next_q.hostAck = ~sdaS;
          end else if (sclFall) begin
            if (q.hostAck) begin
              // Index wraps, so a fifth byte repeats the first.
              next_q.byteIdx = q.byteIdx + 2'h1;
              next_q.bitCnt = 4'h0;
              next_q.state = amp_serial_pkg::READ;
              next_q.sdaOe = ~q.snap[q.byteIdx + 2'h1][7];
            end else begin
              next_q.state = amp_serial_pkg::IDLE;
            end
          end
        end
        amp_serial_pkg::IDLE: begin
          next_q.sdaOe = 1'b0;
        end
        default: begin
          next_q.state = amp_serial_pkg::IDLE;
          next_q.sdaOe = 1'b0;
        end
      endcase
    end
    // Settings follow the pins when the bus is off, else the control bytes.
    next_q.ctl = busOff ? pinCtl : regCtl;
  end

  // State register; control bytes reset to standby with outputs muted.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.state <= amp_serial_pkg::IDLE;
      q.sclPrev <= 1'b1;
      q.sdaPrev <= 1'b1;
      q.ctlFirst <= amp_serial_pkg::CONTROL_FIRST_RESET;
      q.ctlSecond <= amp_serial_pkg::CONTROL_SECOND_RESET;
    end else begin
      q <= next_q;
    end
  end

  // Mute ramps; the fast bit is sampled when a transition starts, which is
  // why the host must clear it afterwards to get the normal time back.
  mute_ramp #(
    .FAST_CYCLES(FAST_MUTE_CYCLES),
    .NORMAL_CYCLES(NORMAL_MUTE_CYCLES)
  ) u_front_ramp (
    .clk(clk),
    .rst(rst),
    .target(q.ctl.unmuteFront),
    .fast(q.ctl.fastMute),
    .unmuted(frontUnmuted)
  );

  mute_ramp #(
    .FAST_CYCLES(FAST_MUTE_CYCLES),
    .NORMAL_CYCLES(NORMAL_MUTE_CYCLES)
  ) u_rear_ramp (
    .clk(clk),
    .rst(rst),
    .target(q.ctl.unmuteRear),
    .fast(q.ctl.fastMute),
    .unmuted(rearUnmuted)
  );

  // The line is open drain: only a low level is ever driven.
  assign sdaOut = 1'b0;
  assign sdaOe = q.sdaOe;
  assign ampControl = q.ctl;
  assign diagRestart = q.diagRestart;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Matched address byte: acknowledge follows the eighth bit.
  sequence s_addr_done;
    (q.state == amp_serial_pkg::ADDR) && (q.bitCnt == 4'h8) && sclFall && !busOff
      && !startCond && !stopCond && (q.shift[7:1] == myAddr);
  endsequence

  property p_start;
    startCond && !busOff |=> (q.state == amp_serial_pkg::ADDR) && (q.bitCnt == 4'h0);
  endproperty
  a_start: assert property (p_start)
    else $error("Start did not open an address byte.");

  property p_stop;
    stopCond && !startCond |=> (q.state == amp_serial_pkg::IDLE) && !q.sdaOe;
  endproperty
  a_stop: assert property (p_stop)
    else $error("Stop did not return to idle.");

  property p_drive_low_clock;
    $rose(q.sdaOe) |-> !$past(sclS);
  endproperty
  a_drive_low_clock: assert property (p_drive_low_clock)
    else $error("Data driver started while clock high.");

  property p_addr_ack;
    s_addr_done |=> (q.state == amp_serial_pkg::ADDR_ACK) && q.sdaOe;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("Matched address not acknowledged.");

  property p_write_ack_hold;
    (q.state == amp_serial_pkg::WRITE_ACK) |-> q.sdaOe;
  endproperty
  a_write_ack_hold: assert property (p_write_ack_hold)
    else $error("Write acknowledge released early.");

  property p_read_dir;
    (q.state == amp_serial_pkg::ADDR_ACK) && q.rw && sclFall
      && !busOff && !startCond && !stopCond
      |=> (q.state == amp_serial_pkg::READ) && (q.sdaOe == !q.snap[0][7]);
  endproperty
  a_read_dir: assert property (p_read_dir)
    else $error("Read address did not start the first status byte.");

  property p_store_first;
    (q.state == amp_serial_pkg::WRITE) && (q.bitCnt == 4'h8) && sclFall
      && (q.byteIdx == 2'h0) && !busOff && !startCond && !stopCond
      |=> (q.ctlFirst == $past(q.shift));
  endproperty
  a_store_first: assert property (p_store_first)
    else $error("First control byte not stored.");

  property p_restart;
    s_addr_done ##0 q.shift[0] |=> q.diagRestart ##1 !q.diagRestart;
  endproperty
  a_restart: assert property (p_restart)
    else $error("Read did not pulse the diagnostic restart.");

  property p_bus_off;
    busOff |=> (q.state == amp_serial_pkg::IDLE) && !q.sdaOe
      && (q.ctl.standbyOff == $past(stbyS)) && (q.ctl.highEffLeft == $past(effS));
  endproperty
  a_bus_off: assert property (p_bus_off)
    else $error("Pin control not in force with bus disabled.");

endmodule // amp_control_diag_serial_port

// ===== amp_control_diag_serial_port_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
// Drives the port through a modelled host and checks the settings and status bytes.
module amp_control_diag_serial_port_tb;
  logic clk, rst, standbyMute, effSel, scl, sda, sdaOe, frontUn, rearUn, restart, sdaLevel;
  logic [1:0] strap;
  logic [3:0] acks;
  logic [7:0] rd [5];
  amp_serial_pkg::diagStatus_type diag;
  amp_serial_pkg::ampControl_type ctl;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int tChange = 0;
  int tDone = 0;
  int restarts = 0;

  host_master host (.sdaOe(sdaOe), .scl(scl), .sda(sda));

  // Short mute counts keep the ramps inside one transfer.
  amp_control_diag_serial_port #(.FAST_MUTE_CYCLES(20), .NORMAL_MUTE_CYCLES(50)) dut (
    .clk(clk), .rst(rst), .sclPin(scl), .sdaIn(sda), .sdaOut(sdaLevel), .sdaOe(sdaOe),
    .addressSelectStrap(strap), .standbyMutePin(standbyMute),
    .efficiencySelectPin(effSel), .diagStatus(diag), .ampControl(ctl),
    .frontUnmuted(frontUn), .rearUnmuted(rearUn), .diagRestart(restart));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Cycle count; blocking so that later updates at the same edge see it.
  always @(posedge clk) begin
    cyc++;
    if (restart === 1'h1) restarts++;
  end
  // Time stamps of a mute target change and of the settled state.
  always @(ctl.unmuteFront) tChange = cyc;
  always @(frontUn) tDone = cyc;

  // Settings expected from two control bytes.
  function automatic amp_serial_pkg::ampControl_type expect_ctl(input logic [7:0] b0, b1);
    return {b0[6:0], b1[7], b1[5:0]};
  endfunction

  // One write transfer of n bytes taken from the top of w.
  task automatic wr(input logic [31:0] w, input int n);
    logic a;
    acks = 4'h0;
    host.start();
    for (int i = 0; i < n; i++) begin
      host.put(w[31-8*i -: 8], a);
      acks[3-i] = a;
    end
    host.stop();
  endtask

  // One read transfer of five status bytes; the fifth should wrap.
  task automatic rdn();
    logic a;
    host.start();
    host.put(8'hd9, a);
    `CHK("read ack", 1'h1, a)
    for (int i = 0; i < 5; i++) host.get(i == 4, rd[i]);
    host.stop();
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    rst = 1'h1;
    strap = 2'h0;
    standbyMute = 1'h0;
    effSel = 1'h0;
    diag = 28'h0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    repeat (6) @(posedge clk);
    `CHK("reset settings", 14'h0, ctl)
    `CHK("reset data drive", 1'h0, sdaOe)
    `CHK("open drain level", 1'h0, sdaLevel)
    // A third write byte is refused; standby out with diagnostics, still muted.
    wr({8'hd8, 8'h79, 8'hbf, 8'h00}, 4);
    `CHK("write acks", 4'he, acks)
    `CHK("settings", expect_ctl(8'h79, 8'hbf), ctl)
    // Front unmute with fast muting armed and offset detection on.
    wr({8'hd8, 8'h7d, 8'hbf, 8'h00}, 3);
    `CHK("fast unmute", 1'h1, frontUn)
    `CHK("fast time", 21, tDone - tChange)
    // Status bytes carry faults and echoes, then the fifth wraps.
    @(posedge clk);
    diag <= {1'h1, 1'h0, 1'h1, 1'h1, 6'h15, 6'h2a, 6'h0f, 6'h30};
    rdn();
    `CHK("status first", 8'hea, rd[0])
    `CHK("status second", 8'h95, rd[1])
    `CHK("status third", 8'hf0, rd[2])
    `CHK("status fourth", 8'h4f, rd[3])
    `CHK("status wrap", 8'hea, rd[4])
    `CHK("restart count", 1, restarts)
    // The fast bit is cleared while still playing, since the first byte of a
    // write lands before the second and would start the ramp with the old bit.
    wr({8'hd8, 8'h7d, 8'h1f, 8'h00}, 3);
    `CHK("fast cleared", 1'h0, ctl.fastMute)
    wr({8'hd8, 8'h79, 8'h1f, 8'h00}, 3);
    `CHK("normal mute", 1'h0, frontUn)
    `CHK("normal time", 51, tDone - tChange)
    // Power-down after the mute: diagnostics off and standby in.
    wr({8'hd8, 8'h00, 8'h00, 8'h00}, 3);
    `CHK("power down", 14'h0, ctl)
    // Address strapping: only the selected address is acknowledged.
    wr({8'hda, 8'h00, 8'h00, 8'h00}, 1);
    `CHK("other address", 4'h0, acks)
    @(posedge clk);
    strap <= 2'h1;
    repeat (4) @(posedge clk);
    wr({8'hda, 8'h00, 8'h00, 8'h00}, 2);
    `CHK("mid strap", 4'hc, acks)
    // Open strap: the bus is ignored and the pins decide.
    @(posedge clk);
    strap <= 2'h2;
    standbyMute <= 1'h1;
    effSel <= 1'h1;
    repeat (6) @(posedge clk);
    `CHK("pin standby", 1'h1, ctl.standbyOff)
    `CHK("pin efficiency", 2'h3, {ctl.highEffRight, ctl.highEffLeft})
    `CHK("pin gain", 2'h3, {ctl.gainFront16, ctl.gainRear16})
    wr({8'hd8, 8'h00, 8'h00, 8'h00}, 1);
    `CHK("bus ignored", 4'h0, acks)
    `CHK("pin rear unmute", 1'h1, rearUn)
    @(posedge clk);
    effSel <= 1'h0;
    repeat (6) @(posedge clk);
    `CHK("pin standard", 2'h0, {ctl.highEffRight, ctl.highEffLeft})
    final_report();
  end
endmodule // amp_control_diag_serial_port_tb

// ===== amp_serial_pkg.sv
package amp_serial_pkg;

  // Core clock rate in MHz.
  localparam int CLK_MHZ = 100;

  // Fast muting must finish in less than this time. The settings register and the
  // ramp's start cycle add two cycles, so the count keeps a small margin below it.
  localparam int FAST_MUTE_US = 1500;
  localparam int FAST_MUTE_MARGIN = 4;
  localparam int FAST_MUTE_CYCLES = FAST_MUTE_US * CLK_MHZ - FAST_MUTE_MARGIN;

  // Normal muting time; the value is a plain default.
  localparam int NORMAL_MUTE_US = 20000;
  localparam int NORMAL_MUTE_CYCLES = NORMAL_MUTE_US * CLK_MHZ;

  // Width of the mute ramp counter; it must hold the normal count.
  localparam int MUTE_CNT_W = 24;

  // Seven-bit slave address with the select bit clear.
  localparam logic [6:0] ADDR_BASE = 7'h6c;

  // Index of the last control byte in a write, and the number of bits in each byte.
  localparam logic [1:0] LAST_CONTROL_INDEX = 2'h1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Field positions of the first control byte.
  localparam int CB1_DIAG_EN = 6;
  localparam int CB1_OFFSET_EN = 5;
  localparam int CB1_GAIN_FRONT = 4;
  localparam int CB1_GAIN_REAR = 3;
  localparam int CB1_UNMUTE_FRONT = 2;
  localparam int CB1_UNMUTE_REAR = 1;
  localparam int CB1_CLIP = 0;

  // Field positions of the second control byte.
  localparam int CB2_LOW_TH = 7;
  localparam int CB2_FAST_MUTE = 5;
  localparam int CB2_STANDBY_OFF = 4;
  localparam int CB2_LINE_DIAG = 3;
  localparam int CB2_PEAK_DIAG = 2;
  localparam int CB2_HE_RIGHT = 1;
  localparam int CB2_HE_LEFT = 0;

  // Reset values of the control bytes: standby, muted, diagnostics off.
  localparam logic [7:0] CONTROL_FIRST_RESET = 8'h00;
  localparam logic [7:0] CONTROL_SECOND_RESET = 8'h00;

  // Decoded settings that drive the amplifier.
  typedef struct packed {
    logic diagEnable;
    logic offsetEnable;
    logic gainFront16;
    logic gainRear16;
    logic unmuteFront;
    logic unmuteRear;
    logic clipTen;
    logic lowCurrentThreshold;
    logic fastMute;
    logic standbyOff;
    logic lineDriverDiag;
    logic peakCurrentDiag;
    logic highEffRight;
    logic highEffLeft;
  } ampControl_type;

  // Fault flags of one channel, in status byte order from bit 5 down.
  typedef struct packed {
    logic openPeak;
    logic permanent;
    logic shortLoad;
    logic openOrOffset;
    logic supplyShort;
    logic groundShort;
  } channelFault_type;

  // Results of the measurement engines; fault index 0 is channel one.
  typedef struct packed {
    logic thermalWarning1;
    logic thermalWarning2;
    logic thermalWarning3;
    logic diagDone;
    channelFault_type [3:0] fault;
  } diagStatus_type;

  // Serial slave states, one-hot.
  typedef enum logic [6:0] {
    IDLE = 7'h01,
    ADDR = 7'h02,
    ADDR_ACK = 7'h04,
    WRITE = 7'h08,
    WRITE_ACK = 7'h10,
    READ = 7'h20,
    READ_ACK = 7'h40
  } busState_type;

endpackage

// ===== host_master.sv
`timescale 1ns/1ns
// Bus master on the far side of the serial port; the data wire has a pull-up.
module host_master (
  input wire logic sdaOe,
  output logic scl,
  output logic sda
);
  logic hostLow; // High while the host pulls the data wire low.

  // Wired-and of both open-drain drivers; a released wire floats high.
  assign sda = !(hostLow || sdaOe);

  // Bus idles with both lines high.
  initial begin
    scl = 1'h1;
    hostLow = 1'h0;
  end

  // One 125 ns clock pulse: data moves only while the clock is low.
  task automatic pulse(input logic low, output logic seen);
    hostLow = low;
    #31 scl = 1'h1;
    #31 seen = sda;
    #32 scl = 1'h0;
    #31;
  endtask

  // Start condition: data falls while the clock is high.
  task automatic start();
    hostLow = 1'h0;
    #31 scl = 1'h1;
    #62 hostLow = 1'h1;
    #62 scl = 1'h0;
    #31;
  endtask

  // Stop condition: data rises while the clock is high.
  task automatic stop();
    hostLow = 1'h1;
    #31 scl = 1'h1;
    #62 hostLow = 1'h0;
    #62;
  endtask

  // Sends one byte and releases the wire for the acknowledge.
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(!b[i], s);
    pulse(1'h0, s);
    ack = !s;
  endtask

  // Receives one byte; the last wanted byte is not acknowledged.
  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'h0, s);
      b[i] = s;
    end
    pulse(!last, s);
  endtask
endmodule // host_master

// ===== mute_ramp.sv
`timescale 1ns/1ns
// Timed mute transition for one channel group.
module mute_ramp #(
  parameter int FAST_CYCLES = amp_serial_pkg::FAST_MUTE_CYCLES,
  parameter int NORMAL_CYCLES = amp_serial_pkg::NORMAL_MUTE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic target,
  input wire logic fast,
  output logic unmuted
);

  // Ramp counter, busy flag and the settled output.
  typedef struct packed {
    logic [amp_serial_pkg::MUTE_CNT_W-1:0] cnt;
    logic busy;
    logic unmuted;
  } rampState_type;

  rampState_type q;
  rampState_type next_q;

  // A new target starts a ramp whose length is picked at the start.
  // A target that flips back mid-ramp is settled at the end of the ramp.
  always_comb begin
    next_q = q;
    if (!q.busy && (target != q.unmuted)) begin
      next_q.busy = 1'b1;
      if (fast) begin
        next_q.cnt = amp_serial_pkg::MUTE_CNT_W'(FAST_CYCLES - 1);
      end else begin
        next_q.cnt = amp_serial_pkg::MUTE_CNT_W'(NORMAL_CYCLES - 1);
      end
    end else if (q.busy) begin
      if (q.cnt == '0) begin
        next_q.busy = 1'b0;
        next_q.unmuted = target;
      end else begin
        next_q.cnt = q.cnt - 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign unmuted = q.unmuted;

  // A fast ramp is loaded with a count that ends before the limit.
  property p_fast_load;
    @(posedge clk) disable iff (rst)
      (!q.busy && (target != q.unmuted) && fast)
        |=> (q.cnt == amp_serial_pkg::MUTE_CNT_W'(FAST_CYCLES - 1));
  endproperty
  a_fast_load: assert property (p_fast_load)
    else $error("Fast mute ramp loaded with wrong length.");

endmodule // mute_ramp

// ===== pin_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for pins from outside the clock domain.
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // First and second stage; only the second stage is read outside.
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } syncState_type;

  syncState_type q;
  syncState_type next_q;

  // The first stage feeds the second and nothing else, to contain metastability.
  always_comb begin
    next_q = q;
    next_q.first = din;
    next_q.second = q.first;
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign dout = q.second;

endmodule // pin_sync
